// ==== pkg/clock_position_defines.vh ====
/*
 * Register offsets, field positions, reset values and delay-step timing
 * for the clock position capture readout.
 * Assumes it is included by bare name from the sampler and capture design files.
 */
`ifndef CLOCK_POSITION_DEFINES_VH
`define CLOCK_POSITION_DEFINES_VH

// Register word indices
`define ADDR_SNAPSHOT_LOW      7'h0b
`define ADDR_SNAPSHOT_HIGH     7'h0c
`define ADDR_DELAY_STEP        7'h0d
`define ADDR_CAPTURE_CONTROL   7'h0e

// Reset values
`define RST_SNAPSHOT           16'h0000
`define RST_DELAY_STEP         16'h0003
`define RST_CAPTURE_CONTROL    16'h0002

// Field positions
`define STEP_LSB               0
`define STEP_MSB               1
`define CTL_LATCH_BIT          0
`define CTL_FUNCTION_BIT       1
`define CTL_CAPTURE_EN_BIT     2
`define CTL_MUTE_BIT           8

// Request pin function codes
`define FUNC_SYNC              1'h0
`define FUNC_FRAME_REQUEST     1'h1

// Delay step per code, in picoseconds
`define STEP_PS_CODE0          28
`define STEP_PS_CODE1          15
`define STEP_PS_CODE2          11
`define STEP_PS_CODE3          8

// Core clock period, in picoseconds
`define MCLK_PERIOD_PS         4000

// Snapshot geometry
`define SNAPSHOT_BITS          32
`define SNAPSHOT_INDEX_BITS    5

`endif

// ==== design/request_edge_arm.v ====
/*
 * Arms on the falling edge of the window clear and fires one pulse on
 * the first rising edge of the request pins seen while armed.
 * Assumes request and clear inputs are synchronous to mclk_in.
 */
`timescale 1ns/1ps
module request_edge_arm
(
	input  wire mclk_in,
	input  wire rst_n_in,
	input  wire window_enable_in,
	input  wire request_window_clear_in,
	input  wire frame_request_input_in,
	output reg  armed_out,
	output reg  trigger_out
);
	reg request_prev;
	reg clear_prev;
	wire request_rise;
	wire clear_fall;

	assign request_rise = frame_request_input_in & ~request_prev;
	assign clear_fall   = clear_prev & ~request_window_clear_in;

	always @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			request_prev <= 1'b0;
			clear_prev   <= 1'b0;
			armed_out    <= 1'b0;
			trigger_out  <= 1'b0;
		end
		else
		begin
			request_prev <= frame_request_input_in;
			clear_prev   <= request_window_clear_in;
			trigger_out  <= 1'b0;
			if (!window_enable_in || request_window_clear_in)
				armed_out <= 1'b0;
			else if (clear_fall)
				armed_out <= 1'b1;
			else if (armed_out && request_rise)
			begin
				armed_out   <= 1'b0;
				trigger_out <= 1'b1;
			end
		end
	end
endmodule

// ==== design/delay_tap_sampler.v ====
/*
 * Walks the delay line tap by tap after a trigger, storing one input
 * clock sample per tap from bit 0 upward, and forces both end bits.
 * Assumes input_clock_sample_in is the delay line output, synchronous.
 */
`timescale 1ns/1ps
`include "clock_position_defines.vh"
module delay_tap_sampler
#(
	parameter WIDTH      = `SNAPSHOT_BITS,
	parameter INDEX_BITS = `SNAPSHOT_INDEX_BITS
)
(
	input  wire             mclk_in,
	input  wire             rst_n_in,
	input  wire             start_in,
	input  wire [1:0]       step_code_in,
	input  wire             input_clock_sample_in,
	output reg  [WIDTH-1:0] snapshot_out,
	output reg              busy_out,
	output reg              done_out
);
	// Steps shorter than one core clock clamp to one cycle per tap
	localparam integer CYC0_WIDE = (`STEP_PS_CODE0 < `MCLK_PERIOD_PS) ? 1
		: `STEP_PS_CODE0 / `MCLK_PERIOD_PS;
	localparam integer CYC1_WIDE = (`STEP_PS_CODE1 < `MCLK_PERIOD_PS) ? 1
		: `STEP_PS_CODE1 / `MCLK_PERIOD_PS;
	localparam integer CYC2_WIDE = (`STEP_PS_CODE2 < `MCLK_PERIOD_PS) ? 1
		: `STEP_PS_CODE2 / `MCLK_PERIOD_PS;
	localparam integer CYC3_WIDE = (`STEP_PS_CODE3 < `MCLK_PERIOD_PS) ? 1
		: `STEP_PS_CODE3 / `MCLK_PERIOD_PS;
	localparam [7:0]   CYC0      = CYC0_WIDE[7:0];
	localparam [7:0]   CYC1      = CYC1_WIDE[7:0];
	localparam [7:0]   CYC2      = CYC2_WIDE[7:0];
	localparam [7:0]   CYC3      = CYC3_WIDE[7:0];

	reg  [INDEX_BITS-1:0] tap;
	reg  [7:0]            spacing;
	reg  [7:0]            wait_count;
	reg  [1:0]            step_held;
	reg  [WIDTH-1:0]      samples;
	wire                  take;

	always @*
	begin
		case (step_held)
			2'h0: spacing = CYC0;
			2'h1: spacing = CYC1;
			2'h2: spacing = CYC2;
			default: spacing = CYC3;
		endcase
	end

	assign take = busy_out && (wait_count == 8'h00);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1)
		begin : g_bit
			always @(posedge mclk_in or negedge rst_n_in)
			begin
				if (!rst_n_in)
					samples[i] <= 1'b0;
				else if (take && tap == i)
					samples[i] <= input_clock_sample_in;
			end
		end
	endgenerate

	always @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			tap          <= {INDEX_BITS{1'b0}};
			wait_count   <= 8'h00;
			step_held    <= 2'h3;
			busy_out     <= 1'b0;
			done_out     <= 1'b0;
			snapshot_out <= {WIDTH{1'b0}};
		end
		else
		begin
			done_out <= 1'b0;
			if (start_in && !busy_out)
			begin
				busy_out   <= 1'b1;
				tap        <= {INDEX_BITS{1'b0}};
				wait_count <= 8'h00;
				step_held  <= step_code_in;
			end
			else if (busy_out)
			begin
				if (wait_count != 8'h00)
					wait_count <= wait_count - 8'h01;
				else if (tap == WIDTH - 1)
				begin
					busy_out     <= 1'b0;
					done_out     <= 1'b1;
					// End taps flag window-edge uncertainty
					snapshot_out <= {1'b1, samples[WIDTH-2:1], 1'b1};
				end
				else
				begin
					tap        <= tap + 1'b1;
					wait_count <= spacing - 8'h01;
				end
			end
		end
	end
endmodule

// ==== design/clock_position_capture.v ====
/*
 * Register file and capture sequencing for the clock position readout:
 * two read-only snapshot words, the delay-step select and the capture
 * control word, with the delay-line sampler and request arming logic.
 * Assumes a simple synchronous register port and synchronous pins.
 */
`timescale 1ns/1ps
`include "clock_position_defines.vh"
module clock_position_capture
(
	input  wire        mclk_in,
	input  wire        rst_n_in,
	input  wire [6:0]  reg_addr_in,
	input  wire        reg_write_in,
	input  wire [15:0] reg_wdata_in,
	input  wire        reg_read_in,
	input  wire        sync_enable_in,
	input  wire        frame_reference_enable_in,
	input  wire        request_window_clear_in,
	input  wire        frame_request_input_in,
	input  wire        input_clock_sample_in,
	output reg  [15:0] reg_rdata_out,
	output reg         reg_rvalid_out,
	output reg  [1:0]  request_delay_step_out,
	output reg         request_pin_function_out,
	output reg         capture_busy_out,
	output reg         capture_done_out
);
	localparam [1:0] ST_IDLE    = 2'b01;
	localparam [1:0] ST_CAPTURE = 2'b10;
	localparam [15:0] STEP_RESET = `RST_DELAY_STEP;
	localparam [15:0] CTL_RESET  = `RST_CAPTURE_CONTROL;

	reg  [1:0]  state;
	reg  [1:0]  next_state;
	reg  [15:0] snapshot_low;
	reg  [15:0] snapshot_high;
	reg  [1:0]  request_delay_step;
	reg         position_capture_enable;
	reg         request_pin_function;
	reg         request_latch;
	reg         sync_mute_release;
	reg  [15:0] next_rdata;
	wire        window_enable;
	wire        trigger;
	wire [31:0] sampled;
	wire        sampler_busy;
	wire        sampler_done;

	// Window runs only with capture enabled and a sync path on
	assign window_enable = position_capture_enable
		& (sync_enable_in | frame_reference_enable_in);

	request_edge_arm u_arm
	(
		.mclk_in                 (mclk_in),
		.rst_n_in                (rst_n_in),
		.window_enable_in        (window_enable),
		.request_window_clear_in (request_window_clear_in),
		.frame_request_input_in  (frame_request_input_in),
		.armed_out               (),
		.trigger_out             (trigger)
	);

	delay_tap_sampler #(
		.WIDTH      (`SNAPSHOT_BITS),
		.INDEX_BITS (`SNAPSHOT_INDEX_BITS)
	) u_sampler
	(
		.mclk_in               (mclk_in),
		.rst_n_in              (rst_n_in),
		.start_in              (trigger && state == ST_IDLE),
		.step_code_in          (request_delay_step),
		.input_clock_sample_in (input_clock_sample_in),
		.snapshot_out          (sampled),
		.busy_out              (sampler_busy),
		.done_out              (sampler_done)
	);

	always @*
	begin
		case (state)
			ST_IDLE:
				next_state = (trigger) ? ST_CAPTURE : ST_IDLE;
			ST_CAPTURE:
				next_state = (sampler_done) ? ST_IDLE : ST_CAPTURE;
			default:
				next_state = ST_IDLE;
		endcase
	end

	always @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state            <= ST_IDLE;
			snapshot_low     <= `RST_SNAPSHOT;
			snapshot_high    <= `RST_SNAPSHOT;
			capture_busy_out <= 1'b0;
			capture_done_out <= 1'b0;
			request_latch    <= 1'b0;
		end
		else
		begin
			state            <= next_state;
			capture_busy_out <= sampler_busy | (next_state == ST_CAPTURE);
			capture_done_out <= sampler_done;
			// Only a finished capture loads the snapshot
			if (sampler_done)
			begin
				snapshot_low  <= sampled[15:0];
				snapshot_high <= sampled[31:16];
			end
			if (request_window_clear_in)
				request_latch <= 1'b0;
			else if (trigger)
				request_latch <= 1'b1;
		end
	end

	// Register writes
	always @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			request_delay_step      <= STEP_RESET[`STEP_MSB:`STEP_LSB];
			position_capture_enable <= CTL_RESET[`CTL_CAPTURE_EN_BIT];
			request_pin_function    <= CTL_RESET[`CTL_FUNCTION_BIT];
			sync_mute_release       <= CTL_RESET[`CTL_MUTE_BIT];
			request_delay_step_out  <= STEP_RESET[`STEP_MSB:`STEP_LSB];
			request_pin_function_out <= CTL_RESET[`CTL_FUNCTION_BIT];
		end
		else
		begin
			if (reg_write_in && reg_addr_in == `ADDR_DELAY_STEP)
				request_delay_step <= reg_wdata_in[`STEP_MSB:`STEP_LSB];
			if (reg_write_in && reg_addr_in == `ADDR_CAPTURE_CONTROL)
			begin
				position_capture_enable <= reg_wdata_in[`CTL_CAPTURE_EN_BIT];
				request_pin_function    <= reg_wdata_in[`CTL_FUNCTION_BIT];
				sync_mute_release       <= reg_wdata_in[`CTL_MUTE_BIT];
			end
			request_delay_step_out   <= request_delay_step;
			request_pin_function_out <= request_pin_function;
		end
	end

	// Read mux; reads never disturb stored values
	always @*
	begin
		next_rdata = 16'h0000;
		case (reg_addr_in)
			`ADDR_SNAPSHOT_LOW:
				next_rdata = snapshot_low;
			`ADDR_SNAPSHOT_HIGH:
				next_rdata = snapshot_high;
			`ADDR_DELAY_STEP:
				next_rdata = {14'h0000, request_delay_step};
			`ADDR_CAPTURE_CONTROL:
				next_rdata = {7'h00, sync_mute_release, 5'h00,
					position_capture_enable, request_pin_function, request_latch};
			default:
				next_rdata = 16'h0000;
		endcase
	end

	always @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			reg_rdata_out  <= 16'h0000;
			reg_rvalid_out <= 1'b0;
		end
		else
		begin
			reg_rvalid_out <= reg_read_in;
			if (reg_read_in)
				reg_rdata_out <= next_rdata;
		end
	end
endmodule

// ==== tb/clock_position_monitor.sv ====
/*
 * Checker for register port timing and capture sequencing.
 * Assumes it is bound to clock_position_capture and sees its ports.
 */
`timescale 1ns/1ps
module clock_position_monitor
(
	input wire        mclk_in,
	input wire        rst_n_in,
	input wire [6:0]  reg_addr_in,
	input wire        reg_write_in,
	input wire [15:0] reg_wdata_in,
	input wire        reg_read_in,
	input wire [15:0] reg_rdata_out,
	input wire        reg_rvalid_out,
	input wire [1:0]  request_delay_step_out,
	input wire        request_pin_function_out,
	input wire        capture_busy_out,
	input wire        capture_done_out
);
	property p_rvalid_follows_read;
		@(posedge mclk_in) disable iff (!rst_n_in) reg_read_in |=> reg_rvalid_out;
	endproperty
	a_rvalid_follows_read: assert property (p_rvalid_follows_read)
		else $error("read strobe got no valid");
	property p_step_reserved_zero;
		@(posedge mclk_in) disable iff (!rst_n_in)
		reg_read_in && reg_addr_in == 7'h0d |=> reg_rdata_out[15:2] == 14'h0000;
	endproperty
	a_step_reserved_zero: assert property (p_step_reserved_zero)
		else $error("step register upper bits not zero");
	property p_unmapped_zero;
		@(posedge mclk_in) disable iff (!rst_n_in)
		reg_read_in && (reg_addr_in < 7'h0b || reg_addr_in > 7'h0e) |=> reg_rdata_out == 16'h0000;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero)
		else $error("unmapped read not zero");
	property p_step_follows_write;
		@(posedge mclk_in) disable iff (!rst_n_in) reg_write_in && reg_addr_in == 7'h0d
		|=> ##1 request_delay_step_out == $past(reg_wdata_in[1:0], 2);
	endproperty
	a_step_follows_write: assert property (p_step_follows_write)
		else $error("step output not the written code");
	property p_function_follows_write;
		@(posedge mclk_in) disable iff (!rst_n_in) reg_write_in && reg_addr_in == 7'h0e
		|=> ##1 request_pin_function_out == $past(reg_wdata_in[1], 2);
	endproperty
	a_function_follows_write: assert property (p_function_follows_write)
		else $error("pin function output not the written bit");
	property p_reset_outputs;
		@(posedge mclk_in) disable iff (!rst_n_in) $rose(rst_n_in)
		|-> request_delay_step_out == 2'h3 && request_pin_function_out && !reg_rvalid_out;
	endproperty
	a_reset_outputs: assert property (p_reset_outputs)
		else $error("outputs not at reset values");
	property p_capture_length;
		@(posedge mclk_in) disable iff (!rst_n_in)
		$rose(capture_busy_out) |-> capture_busy_out[*8] ##[1:40] capture_done_out;
	endproperty
	a_capture_length: assert property (p_capture_length)
		else $error("capture did not finish in time");
	property p_done_after_busy;
		@(posedge mclk_in) disable iff (!rst_n_in) capture_done_out |-> $past(capture_busy_out);
	endproperty
	a_done_after_busy: assert property (p_done_after_busy)
		else $error("done without a capture");
endmodule

bind clock_position_capture clock_position_monitor u_monitor
(
	.mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
	.reg_write_in(reg_write_in), .reg_wdata_in(reg_wdata_in), .reg_read_in(reg_read_in),
	.reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
	.request_delay_step_out(request_delay_step_out),
	.request_pin_function_out(request_pin_function_out),
	.capture_busy_out(capture_busy_out), .capture_done_out(capture_done_out)
);

// ==== tb/request_source_model.sv ====
/*
 * Far side model: window clear, request pin and delay-line samples.
 * Assumes one start pulse per 16 cycles at most.
 */
`timescale 1ns/1ps
module request_source_model
(
	input  wire       mclk_in,
	input  wire       rst_n_in,
	input  wire       start_in,
	input  wire [1:0] sample_mode_in,
	output reg        clear_out,
	output reg        request_out,
	output wire       sample_out
);
	reg [3:0] phase;
	reg       toggle;
	// Mode 0 low, 1 high, 2 or 3 toggling each cycle
	assign sample_out = sample_mode_in[1] ? toggle : sample_mode_in[0];
	always @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			phase <= 4'h0;
			toggle <= 1'b0;
			clear_out <= 1'b0;
			request_out <= 1'b0;
		end
		else
		begin
			phase <= start_in ? 4'h1 : phase + {3'h0, phase != 4'h0};
			// Restart the clock pattern so every capture sees one phase
			toggle <= start_in ? 1'b0 : ~toggle;
			clear_out <= phase == 4'h1;
			request_out <= phase >= 4'h4 && phase <= 4'hc;
		end
	end
endmodule

// ==== tb/clock_position_capture_readout_test.sv ====
/*
 * Self-checking bench for clock_position_capture.
 * Assumes the far side is request_source_model.
 */
`timescale 1ns/1ps
module clock_position_capture_readout_test;
	reg         mclk_in = 1'b0;
	reg         rst_n_in = 1'b0;
	reg  [6:0]  reg_addr_in = 7'h00;
	reg         reg_write_in = 1'b0;
	reg  [15:0] reg_wdata_in = 16'h0000;
	reg         reg_read_in = 1'b0;
	reg         sync_enable_in = 1'b0;
	reg         frame_reference_enable_in = 1'b0;
	reg         start = 1'b0;
	reg  [1:0]  sample_mode = 2'h0;
	wire        clear, request, sample, rvalid, func, busy, done;
	wire [15:0] rdata;
	wire [1:0]  step;
	integer     err_count = 0;
	integer     samples_checked = 0;
	integer     done_count = 0;
	integer     cycles = 0;
	integer     i;
	integer     pairs;
	reg  [31:0] snap;
	reg  [15:0] junk;
	always #2 mclk_in = ~mclk_in;
	clock_position_capture dut
	(
		.mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
		.reg_write_in(reg_write_in), .reg_wdata_in(reg_wdata_in), .reg_read_in(reg_read_in),
		.sync_enable_in(sync_enable_in), .frame_reference_enable_in(frame_reference_enable_in),
		.request_window_clear_in(clear), .frame_request_input_in(request),
		.input_clock_sample_in(sample), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
		.request_delay_step_out(step), .request_pin_function_out(func),
		.capture_busy_out(busy), .capture_done_out(done)
	);
	request_source_model far_side
	(
		.mclk_in(mclk_in), .rst_n_in(rst_n_in), .start_in(start), .sample_mode_in(sample_mode),
		.clear_out(clear), .request_out(request), .sample_out(sample)
	);
	always @(posedge mclk_in)
	begin
		done_count <= done_count + (done === 1'b1);
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			err_count = err_count + 1;
			conclude;
		end
	end
	task check(input string what, input [31:0] exp, input [31:0] got);
	begin
		samples_checked = samples_checked + 1;
		if (got !== exp)
		begin
			$display("unexpected %s expected %h seen %h", what, exp, got);
			err_count = err_count + 1;
		end
	end
	endtask
	task reg_write(input [6:0] a, input [15:0] d);
	begin
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_write_in <= 1'b1;
		@(posedge mclk_in);
		reg_write_in <= 1'b0;
	end
	endtask
	task read_check(input [6:0] a, input [15:0] exp, output [15:0] d);
	begin
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_read_in <= 1'b1;
		@(posedge mclk_in);
		reg_read_in <= 1'b0;
		@(posedge mclk_in);
		check("read valid", 1, rvalid);
		check("read data", exp, rdata);
		d = rdata;
	end
	endtask
	task capture(input e, input f, input [1:0] m, input s_en, input f_en,
		input [31:0] n_done, input [31:0] exp);
	integer d0, n, busy_seen;
	reg [15:0] lo, hi;
	begin
		@(posedge mclk_in);
		sync_enable_in <= s_en;
		frame_reference_enable_in <= f_en;
		reg_write(7'h0e, {13'h0000, e, f, 1'b0});
		@(posedge mclk_in);
		d0 = done_count;
		busy_seen = 0;
		sample_mode <= m;
		start <= 1'b1;
		@(posedge mclk_in);
		start <= 1'b0;
		for (n = 0; n < 100; n = n + 1)
		begin
			@(posedge mclk_in);
			busy_seen = busy_seen | (busy === 1'b1);
		end
		check("done pulses", n_done, done_count - d0);
		check("busy seen", n_done, busy_seen);
		read_check(7'h0b, exp[15:0], lo);
		read_check(7'h0c, exp[31:16], hi);
		read_check(7'h0e, {13'h0000, e, f, n_done[0]}, junk);
		snap = {hi, lo};
	end
	endtask
	task conclude;
	begin
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask
	initial
	begin
		repeat (2) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		snap = 32'h0000_0000;
		read_check(7'h0b, 16'h0000, junk);
		read_check(7'h0c, 16'h0000, junk);
		read_check(7'h0d, 16'h0003, junk);
		read_check(7'h0e, 16'h0002, junk);
		check("pin function", 1, func);
		for (i = 0; i < 4; i = i + 1)
		begin
			reg_write(7'h0d, 16'hfffc | i[15:0]);
			read_check(7'h0d, i[15:0], junk);
			check("step output", i, step);
		end
		reg_write(7'h0b, 16'h1234);
		reg_write(7'h0c, 16'h5678);
		read_check(7'h0b, 16'h0000, junk);
		read_check(7'h0c, 16'h0000, junk);
		read_check(7'h40, 16'h0000, junk);
		// Largest step, as a host would pick in an overlap range
		reg_write(7'h0d, 16'h0000);
		capture(1'b1, 1'b1, 2'h0, 1'b0, 1'b1, 1, 32'h8000_0001);
		capture(1'b1, 1'b0, 2'h1, 1'b1, 1'b0, 1, 32'hffff_ffff);
		check("pin function", 0, func);
		capture(1'b1, 1'b1, 2'h2, 1'b1, 1'b1, 1, 32'haaaa_aaab);
		check("end bits", 32'h8000_0001, snap & 32'h8000_0001);
		check("alternating", 32'h1fff_ffff, {3'h0, snap[29:1] ^ snap[30:2]});
		// Host scan for clock edges: adjacent set bit pairs
		pairs = 0;
		for (i = 0; i < 31; i = i + 1)
			pairs = pairs + (snap[i] & snap[i + 1]);
		check("edge pairs", 1, pairs);
		capture(1'b1, 1'b1, 2'h3, 1'b0, 1'b0, 0, 32'haaaa_aaab);
		capture(1'b0, 1'b1, 2'h1, 1'b1, 1'b1, 0, 32'haaaa_aaab);
		rst_n_in <= 1'b0;
		repeat (2) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		read_check(7'h0b, 16'h0000, junk);
		read_check(7'h0c, 16'h0000, junk);
		read_check(7'h0d, 16'h0003, junk);
		read_check(7'h0e, 16'h0002, junk);
		conclude;
	end
endmodule
